// ---- design/alu_pkg.sv ----
// Constants and types shared by the closing-group ALU datapath.
// Assumes one 200 MHz clock and an asynchronous active-low reset.
package alu_pkg;

	// ==========================================================
	// Operation codes presented by the instruction decoder
	typedef enum logic [3:0] {
		op_none_type_val         = 4'h0,
		literal_minus_acc_op     = 4'h1,
		file_minus_acc_op        = 4'h2,
		file_minus_acc_borrow_op = 4'h3,
		nibble_exchange_op       = 4'h4,
		literal_xor_acc_op       = 4'h5,
		file_xor_acc_op          = 4'h6,
		direction_load_op        = 4'h7,
		sleep_op                 = 4'h8
	} op_type;

	// ==========================================================
	// Execution states, Gray coded along run -> sleep -> wake
	typedef enum logic [1:0] {
		st_run   = 2'b00,
		st_sleep = 2'b01,
		st_wake  = 2'b11
	} state_type;

	// ==========================================================
	// Widths, operand codes and reset values
	localparam int DATA_W            = 8;
	localparam int FILE_ADDR_W       = 7;
	localparam logic [6:0] DIR_A_SEL = 7'h05;
	localparam logic [6:0] DIR_B_SEL = 7'h06;
	localparam logic [6:0] DIR_C_SEL = 7'h07;
	localparam logic [7:0] ACC_RST   = 8'h00;
	localparam logic [7:0] DIR_RST   = 8'hff;
	localparam logic       DEST_ACC  = 1'b0;
	localparam logic [7:0] WDT_CLR   = 8'h00;
	localparam logic [7:0] PRE_CLR   = 8'h00;

endpackage

// ---- design/sub_core.sv ----
// Eight-bit subtractor with nibble borrow output, a - b - borrow.
// Purely combinational; used by the ALU datapath on the same clock.
`timescale 1ns/100ps
module sub_core (
	input  wire logic [7:0] a,
	input  wire logic [7:0] b,
	input  wire logic       borrow_in,
	output logic      [7:0] diff,
	output logic            carry_out,
	output logic            nibble_carry_out
);
	import alu_pkg::*;

	// ==========================================================
	// Add a to the ones complement of b; carry high means no borrow
	logic [8:0] full_sum;
	logic [4:0] low_sum;
	assign full_sum         = {1'b0, a} + {1'b0, ~b} + {8'h00, ~borrow_in};
	assign low_sum          = {1'b0, a[3:0]} + {1'b0, ~b[3:0]} + {4'h0, ~borrow_in};
	assign diff             = full_sum[7:0];
	assign carry_out        = full_sum[8];
	assign nibble_carry_out = low_sum[4];
endmodule

// ---- design/alu_ops.sv ----
// Execution datapath for subtract, swap, exclusive OR, direction load and sleep.
// Assumes the decoder holds op_code, operands and exec_valid for one cycle.
//
// How it works
// [RULE1] Literal-minus-acc writes k minus the accumulator into the accumulator and sets carry and nibble carry when no borrow.
// [RULE2] File-minus-acc subtracts the accumulator from the file operand (address 0..127) and updates carry, nibble carry and zero.
// [RULE3] File operations send the result to the accumulator when dest is 0 and back to the file register when dest is 1.
// [RULE4] Subtract with borrow also takes away the inverted carry flag and routes and flags like the plain subtract.
// [RULE5] Nibble exchange swaps the two halves of the file operand, routes by dest and leaves every flag alone.
// [RULE6] Literal XOR stores acc xor k in the accumulator and updates only the zero flag.
// [RULE7] File XOR routes acc xor file by dest and updates only the zero flag.
// [RULE8] Direction load copies the accumulator into direction A, B or C for operand 5, 6 or 7 with no flag change.
// [RULE9] Sleep clears the watchdog counter and prescaler, sets the timeout status and clears the power-down status.
// [RULE10] After the status update sleep halts execution and stops the oscillator until a wake event.
// [RULE11] Zero is set when the eight-bit result is zero and cleared otherwise.
`timescale 1ns/100ps
module alu_ops (
	input  wire logic                clk,
	input  wire logic                arst_n,
	input  wire logic                exec_valid,
	input  wire alu_pkg::op_type     op_code,
	input  wire logic [7:0]          literal_k,
	input  wire logic [6:0]          file_addr,
	input  wire logic                dest_bit,
	input  wire logic [7:0]          file_rdata,
	input  wire logic                wake_event,
	output logic      [7:0]          acc,
	output logic                     carry_flag,
	output logic                     nibble_borrow_not_bit,
	output logic                     zero_flag,
	output logic                     file_we,
	output logic      [6:0]          file_waddr,
	output logic      [7:0]          file_wdata,
	output logic      [7:0]          port_a_direction,
	output logic      [7:0]          port_b_direction,
	output logic      [7:0]          port_c_direction,
	output logic      [7:0]          watchdog_counter,
	output logic      [7:0]          watchdog_prescaler,
	output logic                     timeout_status,
	output logic                     powerdown_status,
	output logic                     exec_halted,
	output logic                     osc_run
);
	import alu_pkg::*;

	// ==========================================================
	// State
	state_type  state_reg, state_next;
	logic [7:0] acc_reg, dira_reg, dirb_reg, dirc_reg, wdt_reg, pre_reg, fwd_reg;
	logic [6:0] fwa_reg;
	logic       fwe_reg, c_reg, dc_reg, z_reg, to_reg, pd_reg;

	// ==========================================================
	// Operand selection and subtractor
	wire        is_lit_sub  = op_code == literal_minus_acc_op;
	wire        is_sub      = op_code == file_minus_acc_op;
	wire        is_subb     = op_code == file_minus_acc_borrow_op;
	wire        is_swap     = op_code == nibble_exchange_op;
	wire        is_xorl     = op_code == literal_xor_acc_op;
	wire        is_xorf     = op_code == file_xor_acc_op;
	wire        is_dir      = op_code == direction_load_op;
	wire        is_sleep    = op_code == sleep_op;
	wire        running     = state_reg == st_run;
	wire        go          = exec_valid && running; // RULE10
	wire [7:0]  minuend     = is_lit_sub ? literal_k : file_rdata; // RULE1 RULE2
	wire        borrow_in   = is_subb ? ~c_reg : 1'b0; // RULE4
	wire [7:0]  diff;
	wire        sub_c, sub_dc;

	sub_core u_sub (
		.a                (minuend),
		.b                (acc_reg),
		.borrow_in        (borrow_in),
		.diff             (diff),
		.carry_out        (sub_c),
		.nibble_carry_out (sub_dc)
	);

	// ==========================================================
	// Result, routing and flag decode
	wire        any_sub   = is_lit_sub || is_sub || is_subb;
	wire        file_op   = is_sub || is_subb || is_swap || is_xorf;
	wire [7:0]  result    = any_sub ? diff :
	                        is_swap ? {file_rdata[3:0], file_rdata[7:4]} : // RULE5
	                        is_xorl ? (acc_reg ^ literal_k) : // RULE6
	                        (acc_reg ^ file_rdata); // RULE7
	wire        res_valid = go && (any_sub || is_swap || is_xorl || is_xorf);
	wire        to_file   = go && file_op && dest_bit != DEST_ACC; // RULE3
	wire        to_acc    = res_valid && !to_file; // RULE3
	wire        upd_cdc   = go && any_sub; // RULE1 RULE2 RULE4
	wire        upd_z     = go && (any_sub || is_xorl || is_xorf);
	wire        z_val     = result == 8'h00; // RULE11
	wire        sleep_go  = go && is_sleep;

	// ==========================================================
	// Sleep state machine: halts until a wake event
	always_comb begin
		state_next = state_reg;
		unique case (state_reg)
			st_run:   if (sleep_go) state_next = st_sleep; // RULE10
			st_sleep: if (wake_event) state_next = st_wake;
			st_wake:  state_next = st_run;
		endcase
	end

	// ==========================================================
	// Accumulator and flags
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			acc_reg <= ACC_RST;
			c_reg   <= 1'b0;
			dc_reg  <= 1'b0;
			z_reg   <= 1'b0;
		end else begin
			if (to_acc) acc_reg <= result;
			if (upd_cdc) c_reg <= sub_c;
			if (upd_cdc) dc_reg <= sub_dc;
			if (upd_z) z_reg <= z_val; // RULE11
		end
	end

	// ==========================================================
	// File write-back port
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			fwe_reg <= 1'b0;
			fwa_reg <= 7'h00;
			fwd_reg <= 8'h00;
		end else begin
			fwe_reg <= to_file;
			if (to_file) fwa_reg <= file_addr;
			if (to_file) fwd_reg <= result;
		end
	end

	// ==========================================================
	// Direction registers
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			dira_reg <= DIR_RST;
			dirb_reg <= DIR_RST;
			dirc_reg <= DIR_RST;
		end else begin
			if (go && is_dir && file_addr == DIR_A_SEL) dira_reg <= acc_reg; // RULE8
			if (go && is_dir && file_addr == DIR_B_SEL) dirb_reg <= acc_reg; // RULE8
			if (go && is_dir && file_addr == DIR_C_SEL) dirc_reg <= acc_reg; // RULE8
		end
	end

	// ==========================================================
	// Watchdog clear and power status on sleep
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			wdt_reg   <= WDT_CLR;
			pre_reg   <= PRE_CLR;
			to_reg    <= 1'b1;
			pd_reg    <= 1'b1;
			state_reg <= st_run;
		end else begin
			state_reg <= state_next;
			if (sleep_go) begin
				wdt_reg <= WDT_CLR; // RULE9
				pre_reg <= PRE_CLR; // RULE9
				to_reg  <= 1'b1;    // RULE9
				pd_reg  <= 1'b0;    // RULE9
			end else if (osc_run) begin
				{wdt_reg, pre_reg} <= {wdt_reg, pre_reg} + 16'h0001;
			end
		end
	end

	// ==========================================================
	// Outputs
	assign acc                   = acc_reg;
	assign carry_flag            = c_reg;
	assign nibble_borrow_not_bit = dc_reg;
	assign zero_flag             = z_reg;
	assign file_we               = fwe_reg;
	assign file_waddr            = fwa_reg;
	assign file_wdata            = fwd_reg;
	assign port_a_direction      = dira_reg;
	assign port_b_direction      = dirb_reg;
	assign port_c_direction      = dirc_reg;
	assign watchdog_counter      = wdt_reg;
	assign watchdog_prescaler    = pre_reg;
	assign timeout_status        = to_reg;
	assign powerdown_status      = pd_reg;
	assign exec_halted           = !running;
	assign osc_run               = running; // RULE10

	// ==========================================================
	// Checks
	lit_sub_a: assert property (@(posedge clk) disable iff (!arst_n) // RULE1
		go && is_lit_sub |=> acc == $past(literal_k) - $past(acc_reg)
		&& carry_flag == ($past(acc_reg) <= $past(literal_k)))
		else $error("literal subtract wrong");
	file_sub_a: assert property (@(posedge clk) disable iff (!arst_n) // RULE2
		go && is_sub |=> carry_flag == ($past(acc_reg) <= $past(file_rdata)))
		else $error("file subtract carry wrong");
	dest_file_a: assert property (@(posedge clk) disable iff (!arst_n) // RULE3
		go && file_op && dest_bit |=> file_we && acc == $past(acc_reg))
		else $error("dest routing wrong");
	borrow_a: assert property (@(posedge clk) disable iff (!arst_n) // RULE4
		go && is_subb && !dest_bit |=> acc == $past(file_rdata) - $past(acc_reg) - {7'h00, !$past(c_reg)})
		else $error("borrow subtract wrong");
	swap_a: assert property (@(posedge clk) disable iff (!arst_n) // RULE5
		go && is_swap |=> $stable(zero_flag) && $stable(carry_flag) && $stable(nibble_borrow_not_bit))
		else $error("swap touched flags");
	xorl_a: assert property (@(posedge clk) disable iff (!arst_n) // RULE6
		go && is_xorl |=> acc == ($past(acc_reg) ^ $past(literal_k)) && $stable(carry_flag))
		else $error("literal xor wrong");
	xorf_a: assert property (@(posedge clk) disable iff (!arst_n) // RULE7
		go && is_xorf && dest_bit |=> file_wdata == ($past(acc_reg) ^ $past(file_rdata)))
		else $error("file xor wrong");
	dir_b_a: assert property (@(posedge clk) disable iff (!arst_n) // RULE8
		go && is_dir && file_addr == DIR_B_SEL |=> port_b_direction == $past(acc_reg) && $stable(zero_flag))
		else $error("direction load wrong");
	sleep_stat_a: assert property (@(posedge clk) disable iff (!arst_n) // RULE9
		sleep_go |=> timeout_status && !powerdown_status && watchdog_counter == 8'h00)
		else $error("sleep status wrong");
	sleep_halt_a: assert property (@(posedge clk) disable iff (!arst_n) // RULE10
		sleep_go ##1 !wake_event |=> exec_halted && !osc_run)
		else $error("sleep did not halt");
	zero_a: assert property (@(posedge clk) disable iff (!arst_n) // RULE11
		upd_z |=> zero_flag == ((file_we ? file_wdata : acc) == 8'h00))
		else $error("zero flag wrong");
	sleep_c: cover property (@(posedge clk) sleep_go ##[1:5] wake_event);
	subb_c: cover property (@(posedge clk) go && is_subb && !c_reg);
	swap_c: cover property (@(posedge clk) go && is_swap && dest_bit);
endmodule

// ---- test/tb_top.sv ----
// Self-checking bench for the closing-group ALU datapath.
// Assumes alu_pkg is compiled first; drives every port itself, no partner.
`timescale 1ns/100ps
`define CHK(nm, e, g) begin checks_done++; if ((g) !== (e)) begin mismatches++; \
	$display("unexpected %s expected %h seen %h", nm, e, g); end end
module tb_top;
	import alu_pkg::*;
	// ==========================================================
	// Stimulus, observed outputs and reference state
	logic clk = 1'b0, arst_n = 1'b0, exec_valid = 1'b0, dest_bit = 1'b0, wake_event = 1'b0;
	op_type op_code = op_none_type_val;
	logic [7:0] literal_k = 8'h00, file_rdata = 8'h00;
	logic [6:0] file_addr = 7'h00;
	logic [7:0] acc, file_wdata, dir_a, dir_b, dir_c, wdt, pre;
	logic [6:0] file_waddr;
	logic carry_flag, nib_flag, zero_flag, file_we, to_st, pd_st, exec_halted, osc_run;
	logic [7:0] acc_m = 8'h00;
	logic [23:0] dir_m = 24'hffffff;
	logic c_m = 1'b0, dc_m = 1'b0, z_m = 1'b0;
	int mismatches = 0, checks_done = 0, cyc = 0;
	alu_ops uut (.clk(clk), .arst_n(arst_n), .exec_valid(exec_valid), .op_code(op_code), .literal_k(literal_k),
		.file_addr(file_addr), .dest_bit(dest_bit), .file_rdata(file_rdata), .wake_event(wake_event), .acc(acc),
		.carry_flag(carry_flag), .nibble_borrow_not_bit(nib_flag), .zero_flag(zero_flag), .file_we(file_we),
		.file_waddr(file_waddr), .file_wdata(file_wdata), .port_a_direction(dir_a), .port_b_direction(dir_b),
		.port_c_direction(dir_c), .watchdog_counter(wdt), .watchdog_prescaler(pre), .timeout_status(to_st),
		.powerdown_status(pd_st), .exec_halted(exec_halted), .osc_run(osc_run));
	// Clock generation and hang guard
	always #2.5 clk = ~clk;
	always @(posedge clk) begin
		cyc++;
		if (cyc == 2000) begin
			mismatches++;
			end_of_test();
		end
	end
	// ==========================================================
	// Verdict and end of run
	task automatic end_of_test();
		if (mismatches == 0 && checks_done > 0) $display("NO MISMATCHES");
		else $display("MISMATCHES SEEN");
		$finish;
	endtask
	// One instruction: reference result worked out first, then accumulator, flags, file port and direction outputs compared after the edge
	task automatic run(input op_type op, input logic [7:0] k, input logic [7:0] f, input logic [6:0] fa,
		input logic d);
		logic [7:0] r;
		logic fw;
		logic bw;
		r = acc_m;
		fw = 1'b0;
		bw = ~c_m;
		exec_valid = 1'b1;
		op_code = op;
		literal_k = k;
		file_rdata = f;
		file_addr = fa;
		dest_bit = d;
		case (op)
			literal_minus_acc_op: begin
				r = k - acc_m;
				c_m = (acc_m <= k);
				dc_m = (acc_m[3:0] <= k[3:0]);
				z_m = (r == 8'h00);
				acc_m = r;
			end
			file_minus_acc_op, file_minus_acc_borrow_op: begin
				if (op == file_minus_acc_op) bw = 1'b0;
				r = f - acc_m - {7'h00, bw};
				c_m = ({1'b0, acc_m} + {8'h00, bw} <= {1'b0, f});
				dc_m = ({1'b0, acc_m[3:0]} + {4'h0, bw} <= {1'b0, f[3:0]});
				z_m = (r == 8'h00);
				fw = 1'b1;
			end
			nibble_exchange_op: begin
				r = {f[3:0], f[7:4]};
				fw = 1'b1;
			end
			literal_xor_acc_op: begin
				acc_m = acc_m ^ k;
				z_m = (acc_m == 8'h00);
			end
			file_xor_acc_op: begin
				r = acc_m ^ f;
				z_m = (r == 8'h00);
				fw = 1'b1;
			end
			direction_load_op: begin
				if (fa == 7'h05) dir_m[23:16] = acc_m;
				if (fa == 7'h06) dir_m[15:8] = acc_m;
				if (fa == 7'h07) dir_m[7:0] = acc_m;
			end
			default: ;
		endcase
		if (fw && !d) acc_m = r;
		@(posedge clk);
		#1;
		`CHK("acc", acc_m, acc)
		`CHK("carry", c_m, carry_flag)
		`CHK("nibble", dc_m, nib_flag)
		`CHK("zero", z_m, zero_flag)
		`CHK("file_we", fw & d, file_we)
		`CHK("dirs", dir_m, {dir_a, dir_b, dir_c})
		if (fw && d) begin
			`CHK("file_waddr", fa, file_waddr)
			`CHK("file_wdata", r, file_wdata)
		end
	endtask
	// ==========================================================
	// Main sequence
	initial begin
		repeat (4) @(posedge clk);
		#1;
		arst_n = 1'b1;
		`CHK("reset", 27'h7ffffff, {dir_a, dir_b, dir_c, to_st, pd_st, osc_run})
		`CHK("reset rest", 29'h0000000, {acc, carry_flag, nib_flag, zero_flag, file_we, wdt, pre, exec_halted})
		run(literal_xor_acc_op, 8'h03, 8'h00, 7'h00, 1'b0);
		run(literal_minus_acc_op, 8'h05, 8'h00, 7'h00, 1'b0);
		run(literal_minus_acc_op, 8'h02, 8'h00, 7'h00, 1'b0);
		run(literal_xor_acc_op, 8'h1f, 8'h00, 7'h00, 1'b0);
		run(literal_minus_acc_op, 8'h10, 8'h00, 7'h00, 1'b0);
		run(file_minus_acc_op, 8'h00, 8'hf1, 7'h7f, 1'b1);
		run(file_minus_acc_borrow_op, 8'h00, 8'hf1, 7'h00, 1'b1);
		run(file_minus_acc_op, 8'h00, 8'h20, 7'h11, 1'b0);
		run(file_minus_acc_borrow_op, 8'h00, 8'h40, 7'h12, 1'b0);
		run(file_minus_acc_borrow_op, 8'h00, 8'h5e, 7'h13, 1'b1);
		run(file_minus_acc_borrow_op, 8'h00, 8'h5f, 7'h13, 1'b0);
		run(nibble_exchange_op, 8'h00, 8'ha5, 7'h21, 1'b1);
		run(nibble_exchange_op, 8'h00, 8'h3c, 7'h22, 1'b0);
		run(file_xor_acc_op, 8'h00, 8'hc3, 7'h23, 1'b1);
		run(file_xor_acc_op, 8'h00, 8'h0f, 7'h24, 1'b0);
		run(literal_xor_acc_op, 8'hc3, 8'h00, 7'h00, 1'b0);
		for (int i = 5; i < 8; i++) begin
			run(literal_xor_acc_op, 8'(i * 17), 8'h00, 7'h00, 1'b0);
			run(direction_load_op, 8'h00, 8'h00, 7'(i), 1'b0);
		end
		run(op_none_type_val, 8'h12, 8'h34, 7'h05, 1'b1);
		// Let the prescaler pass its first wrap so that the sleep clear is visible in both bytes
		repeat (256) @(posedge clk);
		#1;
		`CHK("watchdog", 16'(cyc - 4), {wdt, pre})
		// Sleep: status bits, watchdog clear, then halt with clock stopped
		run(sleep_op, 8'h00, 8'h00, 7'h00, 1'b0);
		`CHK("sleep status", 19'h40000, {to_st, pd_st, wdt, pre, osc_run})
		`CHK("halted", 1'b1, exec_halted)
		run(literal_xor_acc_op, 8'h00, 8'h00, 7'h00, 1'b0);
		exec_valid = 1'b1;
		literal_k = 8'hff;
		repeat (3) @(posedge clk);
		#1;
		`CHK("asleep", {acc_m, 1'b1, 1'b0, 16'h0000, 1'b0}, {acc, to_st, pd_st, wdt, pre, osc_run})
		exec_valid = 1'b0;
		wake_event = 1'b1;
		@(posedge clk);
		#1;
		wake_event = 1'b0;
		`CHK("wake state", 1'b1, exec_halted)
		@(posedge clk);
		#1;
		`CHK("running", 2'b01, {exec_halted, osc_run})
		run(literal_minus_acc_op, 8'h3f, 8'h00, 7'h00, 1'b0);
		exec_valid = 1'b0;
		end_of_test();
	end
endmodule
